//--- rtl/rtc_calendar_date_regs.sv
`timescale 1ns/100ps
// Function
// - seconds read-only in bits 5:0, 0 to 59
// - minutes read-only in bits 11:6, 0 to 59
// - hours read-only in bits 16:12, 0 to 23, reset zero
// - weekday read-only three bits, 1 Sunday to 7 Saturday, reset Sunday
// - day of month read-only, reset one, limit by month and leap year
// - month read-only four bits, 1 January to 12 December, reset January
// - alarm seconds compared; values 60 to 63 never match
// - alarm minutes compared; values above 59 never match
// - alarm hours compared; values 24 to 31 never match
// - alarm weekday zero is don't care, reset zero
// - alarm day of month five bits, reset zero, 1 to 31 compared
// - alarm month 1 to 12 compared, 13 to 15 never match
// - alarm month or day of month zero drops that field from compare
// - preset copied into running fields on first tick after the write
// - running seconds advance once per one hertz tick when no preset load is pending
// - alarm event after each tick (advance or preset load) when date and year both match
module rtc_calendar_date_regs (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // register bus
  input  rtc_cal_pkg::ahb_req_t      busReq,
  input  wire logic                  hready,
  output rtc_cal_pkg::ahb_rsp_t      busRsp,
  // calendar side
  input  wire logic                  oneHertzTick,
  input  wire logic                  leapYear,
  input  wire logic                  yearMatch,
  output logic                       calendarAlarmEvent
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    rtc_cal_pkg::cal_date_t               run;
    rtc_cal_pkg::cal_date_t               alarm;
    rtc_cal_pkg::cal_date_t               preset;
    logic                                 loadPending;
    logic [2:0]                           sync;
    logic                                 tickLevel;
    logic                                 tickPulse;
    logic                                 cmpPending;
    logic                                 alarmEvent;
    logic                                 dValid;
    logic                                 dWrite;
    logic [rtc_cal_pkg::ADDR_W-1:0]       dAddr;
    logic [rtc_cal_pkg::DATA_W-1:0]       rdata;
  } cal_state_t;

  cal_state_t             s_q;
  cal_state_t             s_d;
  rtc_cal_pkg::cal_date_t stepped;
  logic [4:0]             monthLen;
  logic                   secCarry;
  logic                   minCarry;
  logic                   hourCarry;
  logic                   mdayCarry;
  logic                   advance;
  logic                   addrPhase;
  logic [5:0]             hits;
  logic                   allMatch;

  ////////////////////////////////////////////////////////////////////////////
  // calendar carry chain
  assign advance = s_q.tickPulse & ~s_q.loadPending;

  always_comb begin
    case (s_q.run.monthNum)
      rtc_cal_pkg::MONTH_FEB: begin
        monthLen = leapYear ? rtc_cal_pkg::MDAY_29 : rtc_cal_pkg::MDAY_28;
      end
      rtc_cal_pkg::MONTH_APR,
      rtc_cal_pkg::MONTH_JUN,
      rtc_cal_pkg::MONTH_SEP,
      rtc_cal_pkg::MONTH_NOV: begin
        monthLen = rtc_cal_pkg::MDAY_30;
      end
      default: begin
        monthLen = rtc_cal_pkg::MDAY_31;
      end
    endcase
  end

  cal_field_step #(.W(6), .FIRST(rtc_cal_pkg::SEC_FIRST)) u_secStep (
    .value     (s_q.run.seconds),
    .lastValue (rtc_cal_pkg::SEC_MAX),
    .inc       (advance),
    .nextValue (stepped.seconds),
    .carry     (secCarry)
  );

  cal_field_step #(.W(6), .FIRST(rtc_cal_pkg::SEC_FIRST)) u_minStep (
    .value     (s_q.run.minutes),
    .lastValue (rtc_cal_pkg::MIN_MAX),
    .inc       (secCarry),
    .nextValue (stepped.minutes),
    .carry     (minCarry)
  );

  cal_field_step #(.W(5), .FIRST(rtc_cal_pkg::HOUR_FIRST)) u_hourStep (
    .value     (s_q.run.hours),
    .lastValue (rtc_cal_pkg::HOUR_MAX),
    .inc       (minCarry),
    .nextValue (stepped.hours),
    .carry     (hourCarry)
  );

  cal_field_step #(.W(3), .FIRST(rtc_cal_pkg::WDAY_SUN)) u_wdayStep (
    .value     (s_q.run.weekday),
    .lastValue (rtc_cal_pkg::WDAY_SAT),
    .inc       (hourCarry),
    .nextValue (stepped.weekday),
    .carry     ()
  );

  cal_field_step #(.W(5), .FIRST(rtc_cal_pkg::MDAY_FIRST)) u_mdayStep (
    .value     (s_q.run.monthday),
    .lastValue (monthLen),
    .inc       (hourCarry),
    .nextValue (stepped.monthday),
    .carry     (mdayCarry)
  );

  cal_field_step #(.W(4), .FIRST(rtc_cal_pkg::MONTH_JAN)) u_monthStep (
    .value     (s_q.run.monthNum),
    .lastValue (rtc_cal_pkg::MONTH_DEC),
    .inc       (mdayCarry),
    .nextValue (stepped.monthNum),
    .carry     ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // alarm comparison
  cal_field_match #(.W(6), .MAX_OK(rtc_cal_pkg::SEC_MAX), .ZERO_DC(1'b0)) u_secHit (
    .alarmValue (s_q.alarm.seconds),
    .runValue   (s_q.run.seconds),
    .hit        (hits[0])
  );
  cal_field_match #(.W(6), .MAX_OK(rtc_cal_pkg::MIN_MAX), .ZERO_DC(1'b0)) u_minHit (
    .alarmValue (s_q.alarm.minutes),
    .runValue   (s_q.run.minutes),
    .hit        (hits[1])
  );
  cal_field_match #(.W(5), .MAX_OK(rtc_cal_pkg::HOUR_MAX), .ZERO_DC(1'b0)) u_hourHit (
    .alarmValue (s_q.alarm.hours),
    .runValue   (s_q.run.hours),
    .hit        (hits[2])
  );
  cal_field_match #(.W(3), .MAX_OK(rtc_cal_pkg::WDAY_SAT), .ZERO_DC(1'b1)) u_wdayHit (
    .alarmValue (s_q.alarm.weekday),
    .runValue   (s_q.run.weekday),
    .hit        (hits[3])
  );
  cal_field_match #(.W(5), .MAX_OK(rtc_cal_pkg::MDAY_31), .ZERO_DC(1'b1)) u_mdayHit (
    .alarmValue (s_q.alarm.monthday),
    .runValue   (s_q.run.monthday),
    .hit        (hits[4])
  );
  cal_field_match #(.W(4), .MAX_OK(rtc_cal_pkg::MONTH_DEC), .ZERO_DC(1'b1)) u_monthHit (
    .alarmValue (s_q.alarm.monthNum),
    .runValue   (s_q.run.monthNum),
    .hit        (hits[5])
  );

  assign allMatch = (&hits) & yearMatch;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  assign addrPhase = busReq.hsel & busReq.htrans[1] & hready;

  always_comb begin
    s_d = s_q;
    s_d.sync = {s_q.sync[1:0], oneHertzTick};
    s_d.tickPulse = (s_q.sync[1] == s_q.sync[2]) & s_q.sync[2] & ~s_q.tickLevel;
    if (s_q.sync[1] == s_q.sync[2]) begin
      s_d.tickLevel = s_q.sync[2];
    end
    if (s_q.tickPulse) begin
      if (s_q.loadPending) begin
        s_d.run = s_q.preset;
      end else begin
        s_d.run = stepped;
      end
      s_d.loadPending = 1'b0;
    end
    s_d.cmpPending = s_q.tickPulse;
    s_d.alarmEvent = s_q.cmpPending & allMatch;
    if (s_q.dValid && s_q.dWrite) begin
      case (s_q.dAddr)
        rtc_cal_pkg::OFS_ALARM: begin
          s_d.alarm = busReq.hwdata[rtc_cal_pkg::DATE_W-1:0];
        end
        rtc_cal_pkg::OFS_PRESET: begin
          s_d.preset      = busReq.hwdata[rtc_cal_pkg::DATE_W-1:0];
          s_d.loadPending = 1'b1;
        end
        default: begin
        end
      endcase
    end
    s_d.dValid = addrPhase;
    s_d.dWrite = addrPhase & busReq.hwrite;
    s_d.dAddr  = busReq.haddr;
    if (addrPhase && !busReq.hwrite) begin
      case (busReq.haddr)
        rtc_cal_pkg::OFS_CURRENT: begin
          s_d.rdata = {{(rtc_cal_pkg::DATA_W-rtc_cal_pkg::DATE_W){1'b0}}, s_q.run};
        end
        rtc_cal_pkg::OFS_ALARM: begin
          s_d.rdata = {{(rtc_cal_pkg::DATA_W-rtc_cal_pkg::DATE_W){1'b0}}, s_d.alarm};
        end
        rtc_cal_pkg::OFS_PRESET: begin
          s_d.rdata = {{(rtc_cal_pkg::DATA_W-rtc_cal_pkg::DATE_W){1'b0}}, s_d.preset};
        end
        default: begin
          s_d.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_q             <= '0;
      s_q.run         <= rtc_cal_pkg::CURRENT_RESET;
      s_q.alarm       <= rtc_cal_pkg::ALARM_RESET;
      s_q.preset      <= rtc_cal_pkg::PRESET_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign busRsp.hreadyout   = 1'b1;
  assign busRsp.hresp       = 1'b0;
  assign busRsp.hrdata      = s_q.rdata;
  assign calendarAlarmEvent = s_q.alarmEvent;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_plainTick;
    s_q.tickPulse && !s_q.loadPending;
  endsequence
  sequence s_compare;
    s_q.cmpPending;
  endsequence
  property p_secStep;
    @(posedge mclk) disable iff (!rst_n)
    s_plainTick and (s_q.run.seconds < rtc_cal_pkg::SEC_MAX) |=>
      s_q.run.seconds == $past(s_q.run.seconds) + 6'h01;
  endproperty
  a_secStep: assert property (p_secStep) else $error("seconds did not advance");
  property p_secWrap;
    @(posedge mclk) disable iff (!rst_n)
    s_plainTick and (s_q.run.seconds == rtc_cal_pkg::SEC_MAX) |=>
      (s_q.run.seconds == 6'h00) && (s_q.run.minutes != $past(s_q.run.minutes));
  endproperty
  a_secWrap: assert property (p_secWrap) else $error("seconds carry wrong");
  property p_hold;
    @(posedge mclk) disable iff (!rst_n)
    !s_q.tickPulse |=> $stable(s_q.run);
  endproperty
  a_hold: assert property (p_hold) else $error("running date moved without tick");
  property p_load;
    @(posedge mclk) disable iff (!rst_n)
    s_q.tickPulse && s_q.loadPending |=> (s_q.run == $past(s_q.preset)) &&
      (s_q.loadPending == ($past(s_q.dWrite) && ($past(s_q.dAddr) == rtc_cal_pkg::OFS_PRESET)));
  endproperty
  a_load: assert property (p_load) else $error("preset not loaded on tick");
  property p_wdayWrap;
    @(posedge mclk) disable iff (!rst_n)
    s_plainTick and hourCarry and (s_q.run.weekday == rtc_cal_pkg::WDAY_SAT) |=>
      s_q.run.weekday == rtc_cal_pkg::WDAY_SUN;
  endproperty
  a_wdayWrap: assert property (p_wdayWrap) else $error("weekday wrap wrong");
  property p_febEnd;
    @(posedge mclk) disable iff (!rst_n)
    s_plainTick and hourCarry and (s_q.run.monthNum == rtc_cal_pkg::MONTH_FEB) and
      (s_q.run.monthday == rtc_cal_pkg::MDAY_28) and !leapYear |=>
      (s_q.run.monthday == rtc_cal_pkg::MDAY_FIRST) &&
      (s_q.run.monthNum == 4'h3);
  endproperty
  a_febEnd: assert property (p_febEnd) else $error("february end wrong");
  property p_event;
    @(posedge mclk) disable iff (!rst_n)
    s_compare and allMatch |=> calendarAlarmEvent ##1 !calendarAlarmEvent;
  endproperty
  a_event: assert property (p_event) else $error("alarm event missing");
  property p_noEventIdle;
    @(posedge mclk) disable iff (!rst_n)
    !s_q.cmpPending |=> !calendarAlarmEvent;
  endproperty
  a_noEventIdle: assert property (p_noEventIdle) else $error("event without advance");
  property p_badSec;
    @(posedge mclk) disable iff (!rst_n)
    s_compare and (s_q.alarm.seconds > rtc_cal_pkg::SEC_MAX) |=> !calendarAlarmEvent;
  endproperty
  a_badSec: assert property (p_badSec) else $error("invalid seconds alarm hit");
  property p_badMin;
    @(posedge mclk) disable iff (!rst_n)
    s_compare and (s_q.alarm.minutes > rtc_cal_pkg::MIN_MAX) |=> !calendarAlarmEvent;
  endproperty
  a_badMin: assert property (p_badMin) else $error("invalid minutes alarm hit");
  property p_badHour;
    @(posedge mclk) disable iff (!rst_n)
    s_compare and (s_q.alarm.hours > rtc_cal_pkg::HOUR_MAX) |=> !calendarAlarmEvent;
  endproperty
  a_badHour: assert property (p_badHour) else $error("invalid hours alarm hit");
  property p_badMonth;
    @(posedge mclk) disable iff (!rst_n)
    s_compare and (s_q.alarm.monthNum > rtc_cal_pkg::MONTH_DEC) |=> !calendarAlarmEvent;
  endproperty
  a_badMonth: assert property (p_badMonth) else $error("invalid month alarm hit");
  property p_dontCare;
    @(posedge mclk) disable iff (!rst_n)
    (s_q.alarm.weekday == 3'h0) && (s_q.alarm.monthday == 5'h00) &&
      (s_q.alarm.monthNum == 4'h0) |-> hits[3] && hits[4] && hits[5];
  endproperty
  a_dontCare: assert property (p_dontCare) else $error("zero alarm field compared");
  property p_reserved;
    @(posedge mclk) disable iff (!rst_n)
    s_q.dValid && !s_q.dWrite |-> busRsp.hrdata[31:29] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

endmodule

//--- rtl/rtc_cal_pkg.sv
package rtc_cal_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry and register map
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam int          DATE_W      = 29;
  localparam logic [7:0]  OFS_CURRENT = 8'h00;
  localparam logic [7:0]  OFS_ALARM   = 8'h04;
  localparam logic [7:0]  OFS_PRESET  = 8'h08;

  ////////////////////////////////////////////////////////////////////////////
  // field positions (lsb of each field in every date register)
  localparam int SEC_LSB   = 0;
  localparam int MIN_LSB   = 6;
  localparam int HOUR_LSB  = 12;
  localparam int WDAY_LSB  = 17;
  localparam int MDAY_LSB  = 20;
  localparam int MONTH_LSB = 25;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [28:0] CURRENT_RESET = 29'h0212_0000;
  localparam logic [28:0] ALARM_RESET   = 29'h0000_0000;
  localparam logic [28:0] PRESET_RESET  = 29'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // field limits and codes
  localparam logic [5:0] SEC_MAX    = 6'h3B;
  localparam logic [5:0] MIN_MAX    = 6'h3B;
  localparam logic [5:0] SEC_FIRST  = 6'h00;
  localparam logic [4:0] HOUR_MAX   = 5'h17;
  localparam logic [4:0] HOUR_FIRST = 5'h00;
  localparam logic [2:0] WDAY_SUN   = 3'h1;
  localparam logic [2:0] WDAY_SAT   = 3'h7;
  localparam logic [4:0] MDAY_FIRST = 5'h01;
  localparam logic [4:0] MDAY_28    = 5'h1C;
  localparam logic [4:0] MDAY_29    = 5'h1D;
  localparam logic [4:0] MDAY_30    = 5'h1E;
  localparam logic [4:0] MDAY_31    = 5'h1F;
  localparam logic [3:0] MONTH_JAN  = 4'h1;
  localparam logic [3:0] MONTH_FEB  = 4'h2;
  localparam logic [3:0] MONTH_APR  = 4'h4;
  localparam logic [3:0] MONTH_JUN  = 4'h6;
  localparam logic [3:0] MONTH_SEP  = 4'h9;
  localparam logic [3:0] MONTH_NOV  = 4'hB;
  localparam logic [3:0] MONTH_DEC  = 4'hC;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic [3:0] monthNum;
    logic [4:0] monthday;
    logic [2:0] weekday;
    logic [4:0] hours;
    logic [5:0] minutes;
    logic [5:0] seconds;
  } cal_date_t;

  typedef struct packed {
    logic              hsel;
    logic [ADDR_W-1:0] haddr;
    logic [1:0]        htrans;
    logic              hwrite;
    logic [2:0]        hsize;
    logic [DATA_W-1:0] hwdata;
  } ahb_req_t;

  typedef struct packed {
    logic              hreadyout;
    logic              hresp;
    logic [DATA_W-1:0] hrdata;
  } ahb_rsp_t;

endpackage

//--- rtl/cal_field_step.sv
`timescale 1ns/100ps
module cal_field_step #(
  parameter int           W     = 6,
  parameter logic [W-1:0] FIRST = '0
) (
  // count
  input  wire logic [W-1:0] value,
  input  wire logic [W-1:0] lastValue,
  input  wire logic         inc,
  // result
  output logic      [W-1:0] nextValue,
  output logic              carry
);

  ////////////////////////////////////////////////////////////////////////////
  // wrap at the last value back to the first
  always_comb begin
    carry     = inc & (value >= lastValue);
    nextValue = value;
    if (carry) begin
      nextValue = FIRST;
    end else if (inc) begin
      nextValue = W'(value + 1'b1);
    end
  end

endmodule

//--- rtl/cal_field_match.sv
`timescale 1ns/100ps
module cal_field_match #(
  parameter int           W       = 6,
  parameter logic [W-1:0] MAX_OK  = '1,
  parameter bit           ZERO_DC = 1'b0
) (
  // operands
  input  wire logic [W-1:0] alarmValue,
  input  wire logic [W-1:0] runValue,
  // result
  output logic              hit
);

  ////////////////////////////////////////////////////////////////////////////
  // out-of-range alarm codes never hit; optional zero means don't care
  always_comb begin
    hit = (alarmValue == runValue) && (alarmValue <= MAX_OK);
    if (ZERO_DC && (alarmValue == '0)) begin
      hit = 1'b1;
    end
  end

endmodule

//--- tb/rtc_calendar_date_regs_test.sv
`timescale 1ns/100ps
module rtc_calendar_date_regs_test;
  typedef int f6_t[6];

  ////////////////////////////////////////////////////////////////////////////
  // signals and model state (fields: sec, min, hour, weekday, monthday, month)
  logic                  mclk;
  logic                  rst_n;
  rtc_cal_pkg::ahb_req_t busReq;
  rtc_cal_pkg::ahb_rsp_t busRsp;
  wire logic             hready;
  logic                  oneHertzTick;
  logic                  leapYear;
  logic                  yearMatch;
  logic                  calendarAlarmEvent;
  int                    nMismatch;
  int                    checksDone;
  int                    cycles = 0;
  int                    seed;
  bit                    pend;
  bit                    lp;
  f6_t                   cur;
  f6_t                   pre;
  f6_t                   alm;
  f6_t                   f;
  logic [31:0]           rd;
  f6_t                   cases[7] = '{'{58, 59, 23, 7, 31, 12}, '{59, 59, 23, 3, 28, 2},
                                      '{59, 59, 23, 3, 28, 2}, '{59, 59, 23, 5, 30, 4},
                                      '{59, 59, 23, 1, 29, 2}, '{59, 59, 22, 2, 30, 11},
                                      '{0, 0, 0, 1, 1, 1}};
  bit                    leaps[7] = '{0, 1, 0, 0, 1, 0, 0};

  assign hready = busRsp.hreadyout;

  rtc_calendar_date_regs i_rtc_calendar_date_regs (
    .mclk              (mclk),
    .rst_n             (rst_n),
    .busReq            (busReq),
    .hready            (hready),
    .busRsp            (busRsp),
    .oneHertzTick      (oneHertzTick),
    .leapYear          (leapYear),
    .yearMatch         (yearMatch),
    .calendarAlarmEvent(calendarAlarmEvent)
  );

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // model helpers
  function automatic int rnd(int n);
    return int'($unsigned($random(seed)) % n);
  endfunction

  function automatic logic [31:0] pack(f6_t x);
    return 32'(x[0]) | 32'(x[1]) << 6 | 32'(x[2]) << 12 | 32'(x[3]) << 17
         | 32'(x[4]) << 20 | 32'(x[5]) << 25;
  endfunction

  function automatic int mlen(int mo, bit leap);
    if (mo == 2) return leap ? 29 : 28;
    if (mo == 4 || mo == 6 || mo == 9 || mo == 11) return 30;
    return 31;
  endfunction

  function automatic f6_t step(f6_t x, bit leap);
    x[0] = (x[0] + 1) % 60;
    if (x[0] != 0) return x;
    x[1] = (x[1] + 1) % 60;
    if (x[1] != 0) return x;
    x[2] = (x[2] + 1) % 24;
    if (x[2] != 0) return x;
    x[3] = x[3] % 7 + 1;
    x[4] = x[4] % mlen(x[5], leap) + 1;
    if (x[4] != 1) return x;
    x[5] = x[5] % 12 + 1;
    return x;
  endfunction

  function automatic bit hit(f6_t c, f6_t a);
    hit = (yearMatch === 1'b1);
    for (int k = 0; k < 6; k++) begin
      if (!(k >= 3 && a[k] == 0) && a[k] != c[k]) hit = 1'b0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // checking, bus and tick tasks
  task automatic check(logic [31:0] got, logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      nMismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(logic wr, logic [7:0] a, logic [31:0] wd);
    busReq.hsel   <= 1'b1;
    busReq.haddr  <= a;
    busReq.htrans <= 2'h2;
    busReq.hwrite <= wr;
    do @(posedge mclk); while (hready !== 1'b1);
    busReq.hsel   <= 1'b0;
    busReq.htrans <= 2'h0;
    busReq.hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = busRsp.hrdata;
    check(32'(busRsp.hresp), 32'h0);
  endtask

  task automatic rdChk(logic [7:0] a, logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // pin high four cycles, low four; the event lands inside this window
  task automatic tick();
    int ev;
    ev = 0;
    yearMatch    <= (rnd(4) != 0);
    oneHertzTick <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      if (k == 4) oneHertzTick <= 1'b0;
      @(negedge mclk);
      ev += (calendarAlarmEvent === 1'b1);
      @(posedge mclk);
    end
    if (pend) cur = pre;
    else cur = step(cur, leapYear);
    pend = 1'b0;
    check(32'(ev), 32'(hit(cur, alm)));
    rdChk(8'h00, pack(cur));
  endtask

  task automatic testDone();
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      nMismatch++;
      testDone();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 5;
    rst_n = 1'b0;
    oneHertzTick = 1'b0;
    leapYear = 1'b0;
    yearMatch = 1'b0;
    busReq = '0;
    busReq.hsize = 3'h2;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    cur = '{0, 0, 0, 1, 1, 1};
    rdChk(8'h00, 32'h0212_0000);
    rdChk(8'h04, 32'h0000_0000);
    rdChk(8'h08, 32'h0000_0000);
    rdChk(8'h0C, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'hFFFF_FFFF);
    rdChk(8'h00, 32'h0212_0000);
    bus(1'b1, 8'h04, 32'hFFFF_FFFF);
    rdChk(8'h04, 32'h1FFF_FFFF);
    bus(1'b1, 8'h08, 32'hFFFF_FFFF);
    rdChk(8'h08, 32'h1FFF_FFFF);
    for (int i = 0; i < 10; i++) begin
      if (i < 7) begin
        lp = leaps[i];
        f = cases[i];
      end else begin
        lp = rnd(2);
        f = '{rnd(60), rnd(60), rnd(24), rnd(7) + 1, 0, rnd(12) + 1};
        f[4] = rnd(mlen(f[5], lp)) + 1;
      end
      leapYear <= lp;
      alm = step(f, lp);
      case (i % 6)
        1: begin
          alm[3] = 0;
          alm[4] = 0;
          alm[5] = 0;
        end
        2: alm[0] = 60;
        3: alm[2] = 24;
        4: alm[5] = 13;
        5: alm[1] = 60;
        default: ;
      endcase
      bus(1'b1, 8'h04, pack(alm));
      rdChk(8'h04, pack(alm));
      pre = f;
      pend = 1'b1;
      bus(1'b1, 8'h08, pack(pre));
      rdChk(8'h08, pack(pre));
      repeat (3) tick();
    end
    testDone();
  end
endmodule
